// File: hdl/mdu_pkg.sv
// Package of constants and types for the multiply and divide unit
package mdu_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned DWORD_W = 64;
  localparam int unsigned SIGN_BIT = 31;
  localparam int unsigned CNT_W = 6;
  localparam logic [5:0] DIV_STEPS = 6'h20;
  localparam logic [5:0] MUL_STEPS = 6'h01;
  localparam logic [31:0] RESULT_RST = 32'h00000000;

  typedef enum logic [2:0]
  {
    MDU_OP_NONE = 3'h0,
    MDU_OP_SMUL = 3'h1,
    MDU_OP_UMUL = 3'h2,
    MDU_OP_SDIV = 3'h3,
    MDU_OP_UDIV = 3'h4,
    MDU_OP_RDUP = 3'h5,
    MDU_OP_RDBT = 3'h6
  } mdu_op_e;

  typedef enum logic [2:0]
  {
    MDU_ST_IDLE = 3'b001,
    MDU_ST_MUL = 3'b010,
    MDU_ST_DIV = 3'b100
  } mdu_state_e;

  // Sign-extend a 32-bit value to 64 bits
  function automatic logic [63:0] mduSext(input logic [31:0] v);
    mduSext = {{32{v[SIGN_BIT]}}, v};
  endfunction

  // Magnitude of a two's complement word
  function automatic logic [31:0] mduAbs(input logic [31:0] v, input logic sgn);
    mduAbs = (sgn && v[SIGN_BIT]) ? 32'(-v) : v;
  endfunction
endpackage

// File: hdl/mdu_result_regs.sv
// Upper and bottom result register pair with registered read port
module mdu_result_regs
  import mdu_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [31:0] wrUpper,
  input wire logic [31:0] wrBottom,
  input wire logic rdEn,
  input wire logic rdSelUpper,
  output logic [31:0] rdData,
  output logic [31:0] upperNow,
  output logic [31:0] bottomNow
);
  logic [31:0] upper_r;
  logic [31:0] bottom_r;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      upper_r <= RESULT_RST;
      bottom_r <= RESULT_RST;
    end
    else if (wrEn)
    begin
      upper_r <= wrUpper;
      bottom_r <= wrBottom;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdData <= RESULT_RST;
    else if (rdEn)
      rdData <= rdSelUpper ? upper_r : bottom_r;
  end

  assign upperNow = upper_r;
  assign bottomNow = bottom_r;
endmodule

// File: hdl/mdu_divider.sv
// Iterative restoring divider, one quotient bit per clock
module mdu_divider
  import mdu_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic isSigned,
  input wire logic [31:0] dividend,
  input wire logic [31:0] divisor,
  output logic done,
  output logic [31:0] quotient,
  output logic [31:0] remainder
);
  logic [31:0] quo_r;
  logic [32:0] rem_r;
  logic [31:0] dvs_r;
  logic [5:0] cnt_r;
  logic negQuo_r;
  logic negRem_r;
  logic busy_r;
  logic [32:0] trial;
  logic [32:0] shifted;

  always_comb
  begin
    shifted = {rem_r[31:0], quo_r[31]};
    trial = shifted - {1'b0, dvs_r};
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      quo_r <= RESULT_RST;
      rem_r <= '0;
      dvs_r <= RESULT_RST;
      cnt_r <= '0;
      negQuo_r <= 1'b0;
      negRem_r <= 1'b0;
      busy_r <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        quo_r <= mduAbs(dividend, isSigned);
        dvs_r <= mduAbs(divisor, isSigned);
        rem_r <= '0;
        cnt_r <= DIV_STEPS;
        negQuo_r <= isSigned && (dividend[SIGN_BIT] ^ divisor[SIGN_BIT]);
        negRem_r <= isSigned && dividend[SIGN_BIT];
        busy_r <= 1'b1;
      end
      else if (busy_r)
      begin
        // Zero divisor just runs through: result undefined, no trap
        if (trial[32])
        begin
          rem_r <= shifted;
          quo_r <= {quo_r[30:0], 1'b0};
        end
        else
        begin
          rem_r <= trial;
          quo_r <= {quo_r[30:0], 1'b1};
        end
        cnt_r <= cnt_r - 6'h01;
        if (cnt_r == MUL_STEPS)
        begin
          busy_r <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  // Sign correction applied on the final values
  assign quotient = negQuo_r ? 32'(-quo_r) : quo_r;
  assign remainder = negRem_r ? 32'(-rem_r[31:0]) : rem_r[31:0];
endmodule

// File: hdl/mdu_unit.sv
// Multiply and divide unit with upper and bottom result registers
// How it works
// - Signed product treats operands as two's complement
// - Unsigned product treats operands as unsigned
// - Product low word bottom, high word upper
// - No overflow exception from any operation
// - 64-bit mode sign-extends each product half
// - Signed divide: quotient bottom, remainder upper
// - Unsigned divide places results the same way
// - Zero divisor gives undefined result, no trap
// - 64-bit mode sign-extends quotient and remainder
// - Read-upper copies upper register to destination
// - Read-bottom copies bottom register to destination
module mdu_unit
  import mdu_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic opValid,
  input wire logic [2:0] opCode,
  input wire logic [63:0] firstOperand,
  input wire logic [63:0] secondOperandReg,
  input wire logic [4:0] destIndex,
  input wire logic mode64,
  output logic busy,
  output logic resultValid,
  output logic [63:0] resultData,
  output logic [4:0] resultIndex,
  output logic overflowTrap
);
  mdu_state_e state_r;
  logic mode64_r;
  logic [63:0] product;
  logic [31:0] rdData;
  logic wrEn;
  logic [31:0] wrUpper;
  logic [31:0] wrBottom;
  logic divStart;
  logic divDone;
  logic [31:0] quotient;
  logic [31:0] remainder;
  logic rdEn;
  logic rdPend_r;
  logic [4:0] rdIdx_r;
  logic [63:0] prodReg_r;
  logic isMul;
  logic isDiv;
  logic isRead;

  // Operands use the low word; upper half ignored
  always_comb
  begin
    isMul = opValid && !busy && (opCode == MDU_OP_SMUL || opCode == MDU_OP_UMUL);
    isDiv = opValid && !busy && (opCode == MDU_OP_SDIV || opCode == MDU_OP_UDIV);
    isRead = opValid && !busy && (opCode == MDU_OP_RDUP || opCode == MDU_OP_RDBT);
    // Full-width operands so the product keeps all 64 bits
    if (opCode == MDU_OP_SMUL)
      product = mduSext(firstOperand[31:0]) * mduSext(secondOperandReg[31:0]);
    else
      product = {RESULT_RST, firstOperand[31:0]} * {RESULT_RST, secondOperandReg[31:0]};
  end

  assign divStart = isDiv;
  assign rdEn = isRead;

  // Results written after the operation completes
  always_comb
  begin
    wrEn = 1'b0;
    wrUpper = prodReg_r[63:32];
    wrBottom = prodReg_r[31:0];
    if (state_r == MDU_ST_MUL)
    begin
      wrEn = 1'b1;
    end
    else if (state_r == MDU_ST_DIV && divDone)
    begin
      wrEn = 1'b1;
      wrUpper = remainder;
      wrBottom = quotient;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= MDU_ST_IDLE;
      prodReg_r <= '0;
      mode64_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        MDU_ST_IDLE:
        begin
          mode64_r <= mode64;
          if (isMul)
          begin
            prodReg_r <= product;
            state_r <= MDU_ST_MUL;
          end
          else if (isDiv)
            state_r <= MDU_ST_DIV;
        end
        MDU_ST_MUL:
          state_r <= MDU_ST_IDLE;
        MDU_ST_DIV:
          if (divDone)
            state_r <= MDU_ST_IDLE;
        default:
          state_r <= MDU_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      busy <= 1'b0;
    else if (isMul || isDiv)
      busy <= 1'b1;
    else if (wrEn)
      busy <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdPend_r <= 1'b0;
      rdIdx_r <= '0;
    end
    else
    begin
      rdPend_r <= rdEn;
      if (rdEn)
        rdIdx_r <= destIndex;
    end
  end

  // Read data passes back to the register file a cycle later
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resultValid <= 1'b0;
      resultData <= '0;
      resultIndex <= '0;
    end
    else
    begin
      resultValid <= rdPend_r;
      resultIndex <= rdIdx_r;
      if (mode64_r)
        resultData <= mduSext(rdData);
      else
        resultData <= {RESULT_RST, rdData};
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      overflowTrap <= 1'b0;
    else
      overflowTrap <= 1'b0;
  end

  mdu_result_regs uRegs
  (
    .clock(clock),
    .rst_n(rst_n),
    .wrEn(wrEn),
    .wrUpper(wrUpper),
    .wrBottom(wrBottom),
    .rdEn(rdEn),
    .rdSelUpper(opCode == MDU_OP_RDUP),
    .rdData(rdData),
    .upperNow(),
    .bottomNow()
  );

  mdu_divider uDiv
  (
    .clock(clock),
    .rst_n(rst_n),
    .start(divStart),
    .isSigned(opCode == MDU_OP_SDIV),
    .dividend(firstOperand[31:0]),
    .divisor(secondOperandReg[31:0]),
    .done(divDone),
    .quotient(quotient),
    .remainder(remainder)
  );
endmodule

// File: tb/mdu_unit_monitor.sv
// Port timing checker for the multiply and divide unit
module mdu_unit_monitor
  import mdu_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic opValid,
  input wire logic [2:0] opCode,
  input wire logic [63:0] firstOperand,
  input wire logic [63:0] secondOperandReg,
  input wire logic [4:0] destIndex,
  input wire logic mode64,
  input wire logic busy,
  input wire logic resultValid,
  input wire logic [63:0] resultData,
  input wire logic [4:0] resultIndex,
  input wire logic overflowTrap
);
  timeunit 1ns;
  timeprecision 100ps;
  logic takeRd;
  logic takeMul;
  logic takeDiv;
  assign takeRd = opValid && !busy && (opCode == 3'h5 || opCode == 3'h6);
  assign takeMul = opValid && !busy && (opCode == 3'h1 || opCode == 3'h2);
  assign takeDiv = opValid && !busy && (opCode == 3'h3 || opCode == 3'h4);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  chk_no_trap: assert property (!overflowTrap)
    else $error("overflow trap raised");
  chk_read_timing: assert property (takeRd |-> ##2 resultValid)
    else $error("read result late");
  chk_read_dest: assert property (takeRd |-> ##2 resultIndex == $past(destIndex, 2))
    else $error("read destination wrong");
  chk_valid_cause: assert property (resultValid |-> $past(takeRd, 2))
    else $error("result valid without read");
  chk_mul_busy: assert property (takeMul |=> busy ##1 !busy)
    else $error("product busy window wrong");
  chk_div_busy: assert property (takeDiv |-> ##1 busy ##32 busy ##1 !busy)
    else $error("divide busy window wrong");
  chk_sign_fill: assert property (resultValid |->
    resultData[63:32] == ($past(mode64, 2) ? {32{resultData[31]}} : 32'h00000000))
    else $error("upper half fill wrong");
  chk_busy_cause: assert property ($rose(busy) |-> $past(takeMul || takeDiv))
    else $error("busy without request");
endmodule

bind mdu_unit mdu_unit_monitor mon_u (.clock, .rst_n, .opValid, .opCode, .firstOperand, .secondOperandReg,
  .destIndex, .mode64, .busy, .resultValid, .resultData, .resultIndex, .overflowTrap);

// File: tb/mdu_issue_model.sv
// Model of the decode stage that issues operations to the unit
module mdu_issue_model
  import mdu_pkg::*;
(
  input wire logic clock,
  input wire logic busy,
  output logic opValid,
  output logic [2:0] opCode,
  output logic [63:0] firstOperand,
  output logic [63:0] secondOperandReg,
  output logic [4:0] destIndex,
  output logic mode64
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    opValid = 1'b0;
    opCode = 3'h0;
    firstOperand = 64'h0;
    secondOperandReg = 64'h0;
    destIndex = 5'h00;
    mode64 = 1'b0;
  end
  // Returns just after the edge that took the request
  task automatic issue(input logic [2:0] op, input logic [31:0] a, input logic [31:0] b,
    input logic [4:0] d, input logic m);
    repeat (2) @(posedge clock);
    #1;
    opValid = 1'b1;
    opCode = op;
    firstOperand = {{32{a[31]}}, a};
    secondOperandReg = {{32{b[31]}}, b};
    destIndex = d;
    mode64 = m;
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge clock) #1;
    @(posedge clock);
    #1;
    opValid = 1'b0;
  endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for the multiply and divide unit
module tb
  import mdu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst_n, opValid, mode64, busy, resultValid, overflowTrap;
  logic [2:0] opCode;
  logic [63:0] firstOperand, secondOperandReg, resultData;
  logic [4:0] destIndex, resultIndex;
  int errors, cmpCount, cycles;

  mdu_unit dut_u (.clock, .rst_n, .opValid, .opCode, .firstOperand, .secondOperandReg, .destIndex, .mode64,
    .busy, .resultValid, .resultData, .resultIndex, .overflowTrap);
  mdu_issue_model host_u (.clock, .busy, .opValid, .opCode, .firstOperand, .secondOperandReg, .destIndex,
    .mode64);

  task automatic report_and_stop();
    if (errors == 0 && cmpCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic read_word(input logic [2:0] op, input logic m, input logic [31:0] w);
    host_u.issue(op, 32'h0, 32'h0, 5'h0A, m);
    // Read result stands for one cycle only
    @(posedge clock);
    #1;
    check("resultValid", 64'(resultValid), 64'h1);
    check("resultIndex", 64'(resultIndex), 64'h0A);
    check("resultData", resultData, m ? {{32{w[31]}}, w} : {32'h0, w});
  endtask

  task automatic run_op(input logic [2:0] op, input logic [31:0] a, input logic [31:0] b, input logic m,
    input logic [31:0] hi, input logic [31:0] lo);
    host_u.issue(op, a, b, 5'h03, m);
    for (int i = 0; i < 40 && busy === 1'b1; i++) @(posedge clock) #1;
    check("busy", 64'(busy), 64'h0);
    check("overflowTrap", 64'(overflowTrap), 64'h0);
    read_word(MDU_OP_RDUP, m, hi);
    read_word(MDU_OP_RDBT, m, lo);
  endtask

  task automatic sc_mul_signed();
    logic signed [63:0] p;
    p = $signed(32'hFFFFFFFD) * $signed(32'h00000007);
    run_op(MDU_OP_SMUL, 32'hFFFFFFFD, 32'h00000007, 1'b0, p[63:32], p[31:0]);
    p = $signed(32'h80000000) * $signed(32'h7FFFFFFF);
    run_op(MDU_OP_SMUL, 32'h80000000, 32'h7FFFFFFF, 1'b1, p[63:32], p[31:0]);
  endtask

  task automatic sc_mul_unsigned();
    logic [63:0] u;
    u = 32'hFFFFFFFF * 32'hFFFFFFFF;
    run_op(MDU_OP_UMUL, 32'hFFFFFFFF, 32'hFFFFFFFF, 1'b1, u[63:32], u[31:0]);
  endtask

  task automatic sc_divide();
    logic signed [31:0] q, r;
    q = $signed(32'hFFFFFFF9) / $signed(32'h00000002);
    r = $signed(32'hFFFFFFF9) % $signed(32'h00000002);
    run_op(MDU_OP_SDIV, 32'hFFFFFFF9, 32'h00000002, 1'b1, r, q);
    run_op(MDU_OP_UDIV, 32'hFFFFFFF9, 32'h00000002, 1'b0, 32'h00000001, 32'h7FFFFFFC);
  endtask

  task automatic sc_div_zero();
    host_u.issue(MDU_OP_UDIV, 32'h12345678, 32'h00000000, 5'h01, 1'b0);
    for (int i = 0; i < 40 && busy === 1'b1; i++) @(posedge clock) #1;
    check("busy", 64'(busy), 64'h0);
    check("overflowTrap", 64'(overflowTrap), 64'h0);
  endtask

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      report_and_stop();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    rst_n = 1'b1;
    sc_mul_signed();
    sc_mul_unsigned();
    sc_divide();
    sc_div_zero();
    report_and_stop();
  end
endmodule
